// ==== efp_pkg.sv ====
// constants, types and helper functions for the embedded flash controller
package efp_pkg;
    localparam int BANKS = 4;
    localparam int WLS = 128;
    localparam int WL_BYTES = 32;
    localparam int CW_W = 13;
    localparam int SECTORS = 10;
    localparam logic [15:0] ROW_STEP = 16'h0020;
    localparam logic [15:0] BANK_MASK = 16'hF000;
    localparam logic [15:0] P0_BASE = 16'h0000;
    localparam logic [15:0] P1_BASE = 16'h1000;
    localparam logic [15:0] P2_BASE = 16'h2000;
    localparam logic [15:0] D_BASE = 16'hA000;
    localparam logic [1:0] D_BANK = 2'h3;
    localparam logic [1:0] D_PROG_LIMIT = 2'h2;
    localparam logic [CW_W-1:0] ERASED_CW = 13'h1EEE;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    localparam int PACE_CYCLES_DEF = 16;
    localparam int PACE_STEPS_DEF = 4;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_ROW_PTR = 8'h04;
    localparam logic [7:0] OFS_WBUF = 8'h08;
    localparam logic [7:0] OFS_ERASE = 8'h0C;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_RD_ADDR = 8'h14;
    localparam logic [7:0] OFS_RD_DATA = 8'h18;
    localparam logic [7:0] OFS_FAULT_LO = 8'h1C;
    localparam logic [7:0] OFS_FAULT_HI = 8'h20;
    localparam logic [7:0] OFS_INJECT = 8'h24;
    localparam int CTRL_PD_BIT = 0;
    localparam int CTRL_PROG_BIT = 1;
    localparam int CTRL_ERASE_BIT = 2;
    localparam int ST_CARRY_BIT = 0;
    localparam int ST_PEN_BIT = 1;
    localparam int ST_PFLAG_BIT = 2;
    localparam int ST_ECC_BIT = 3;
    localparam logic [15:0] ROW_PTR_RST = D_BASE;

    typedef enum logic [1:0] {mode_ready, mode_prog, mode_erase, mode_pdown} efp_mode_t;

    // bit 2 set when the address falls in a bank, bits 1:0 the bank
    function automatic logic [2:0] addr_bank(input logic [15:0] a);
        case (a & BANK_MASK)
            P0_BASE: addr_bank = 3'h4;
            P1_BASE: addr_bank = 3'h5;
            P2_BASE: addr_bank = 3'h6;
            D_BASE: addr_bank = 3'h7;
            default: addr_bank = 3'h0;
        endcase
    endfunction

    // sector that holds a wordline
    function automatic logic [3:0] wl_sector(input logic d_bank, input logic [6:0] wl);
        if (d_bank) begin
            if (wl < 7'd32) wl_sector = 4'h0;
            else if (wl < 7'd64) wl_sector = 4'h1;
            else if (wl < 7'd80) wl_sector = 4'h2;
            else if (wl < 7'd96) wl_sector = 4'h3;
            else if (wl < 7'd112) wl_sector = 4'h4;
            else if (wl < 7'd120) wl_sector = 4'h5;
            else wl_sector = 4'h6 + {2'h0, wl[2:1]} - 4'h0;
        end else begin
            if (wl < 7'd120) wl_sector = 4'h0;
            else if (wl < 7'd124) wl_sector = 4'h1;
            else wl_sector = 4'h2;
        end
    endfunction
endpackage

// ==== efp_ecc.sv ====
// hamming secded encoder and decoder for one byte
`timescale 1ns/10ps
`default_nettype none
module efp_ecc
    import efp_pkg::*;
(
    input wire logic [7:0] enc_data,
    output logic [CW_W-1:0] enc_code,
    input wire logic [CW_W-1:0] dec_code,
    output logic [7:0] dec_data,
    output logic dec_single,
    output logic dec_double
);
    logic [CW_W-1:0] w;
    logic [CW_W-1:0] c;
    logic [3:0] esyn;
    logic [3:0] dsyn;
    logic perr;

    // encode: data at non power-of-two positions, parity from syndrome
    always_comb begin
        w = '0;
        w[3] = enc_data[0];
        w[5] = enc_data[1];
        w[6] = enc_data[2];
        w[7] = enc_data[3];
        w[9] = enc_data[4];
        w[10] = enc_data[5];
        w[11] = enc_data[6];
        w[12] = enc_data[7];
        esyn = 4'h0;
        for (int i = 1; i < CW_W; i++) begin
            if (w[i]) esyn = esyn ^ 4'(i);
        end
        w[1] = esyn[0];
        w[2] = esyn[1];
        w[4] = esyn[2];
        w[8] = esyn[3];
        w[0] = ^w[CW_W-1:1];
        enc_code = w;
    end

    // decode: correct single errors, flag double errors
    always_comb begin
        c = dec_code;
        dsyn = 4'h0;
        for (int i = 1; i < CW_W; i++) begin
            if (c[i]) dsyn = dsyn ^ 4'(i);
        end
        perr = ^c;
        dec_single = perr & (dsyn < 4'd13);
        dec_double = (~perr & (dsyn != 4'h0)) | (perr & (dsyn > 4'd12));
        if (dec_single && dsyn != 4'h0) c[dsyn] = ~c[dsyn];
        dec_data = {c[12], c[11], c[10], c[9], c[7], c[6], c[5], c[3]};
    end
endmodule // efp_ecc
`default_nettype wire

// ==== efp_bank_fsm.sv ====
// per-bank operating mode state machine
`timescale 1ns/10ps
`default_nettype none
module efp_bank_fsm
    import efp_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic go_prog,
    input wire logic go_erase,
    input wire logic seq_done,
    input wire logic pd_req,
    output var efp_mode_t mode
);
    efp_mode_t mode_r;
    efp_mode_t mode_nxt;

    // only ready leads to program or erase
    always_comb begin
        mode_nxt = mode_r;
        case (mode_r)
            mode_ready: begin
                if (pd_req) mode_nxt = mode_pdown;
                else if (go_prog) mode_nxt = mode_prog;
                else if (go_erase) mode_nxt = mode_erase;
            end
            mode_prog, mode_erase: begin
                if (seq_done) mode_nxt = pd_req ? mode_pdown : mode_ready;
            end
            mode_pdown: begin
                if (!pd_req) mode_nxt = mode_ready;
            end
            default: mode_nxt = mode_ready;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) mode_r <= mode_ready;
        else mode_r <= mode_nxt;
    end

    assign mode = mode_r;
endmodule // efp_bank_fsm
`default_nettype wire

// ==== efp_flash_ctrl.sv ====
// flash program/erase sequencer with ecc and apb register slave
`timescale 1ns/10ps
`default_nettype none
module efp_flash_ctrl
    import efp_pkg::*;
#(
    parameter int PACE_CYCLES = PACE_CYCLES_DEF,
    parameter int PACE_STEPS = PACE_STEPS_DEF
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic pump_enable,
    output logic ecc_nmi,
    output logic pacing_nmi
);
    localparam logic [15:0] PACE_RELOAD = 16'(PACE_CYCLES - 1);
    localparam logic [7:0] PACE_LAST = 8'(PACE_STEPS - 1);

    // flash cells, one wordline of codewords per entry
    logic [CW_W*WL_BYTES-1:0] cells_r [BANKS*WLS];
    logic [BANKS*WLS-1:0] blank_r;
    logic [1:0] dcnt_r [WLS];
    logic [7:0] wbuf_r [BANKS][WL_BYTES];

    logic power_down_request_r;
    logic [15:0] row_address_pointer_r;
    logic [9:0] erase_mask_r;
    logic [1:0] erase_bank_r;
    logic [15:0] rd_addr_r;
    logic [CW_W-1:0] inject_r;
    logic request_error_carry_r;
    logic pacing_timer_nmi_enable_r;
    logic pacing_timer_nmi_flag_r;
    logic ecc_flag_r;
    logic [7:0] ecc_fault_addr_low_r;
    logic [7:0] ecc_fault_addr_high_r;

    logic seq_active_r;
    logic seq_erase_r;
    logic [1:0] seq_bank_r;
    logic [6:0] seq_wl_r;
    logic [9:0] seq_mask_r;
    logic [15:0] pace_cnt_r;
    logic [7:0] step_cnt_r;

    efp_mode_t bank_mode [BANKS];
    logic [7:0] mode_bits;

    logic wr_acc;
    logic rd_setup;
    logic rd_acc;
    logic addr_hit;
    logic prog_go;
    logic erase_go;
    logic [2:0] ptr_dec;
    logic ptr_ok;
    logic limit_hit;
    logic prog_accept;
    logic erase_accept;
    logic underflow;
    logic seq_done;
    logic [8:0] seq_idx;
    logic seq_blank;
    logic [CW_W*WL_BYTES-1:0] seq_word;
    wire [CW_W*WL_BYTES-1:0] new_word;

    logic [2:0] rd_dec;
    logic [8:0] rd_idx;
    logic [CW_W*WL_BYTES-1:0] rd_word;
    logic [CW_W-1:0] rd_code;
    logic [7:0] rd_byte;
    logic rd_single;
    logic rd_double;
    logic rd_blocked;
    logic ecc_event;

    // apb decode, zero wait states
    assign wr_acc = psel & penable & pwrite & (pstrb != 4'h0);
    assign rd_setup = psel & ~penable & ~pwrite;
    assign rd_acc = psel & penable & ~pwrite;
    assign pready = 1'b1;

    always_comb begin
        case (paddr)
            OFS_CTRL, OFS_ROW_PTR, OFS_WBUF, OFS_ERASE, OFS_STATUS, OFS_RD_ADDR,
            OFS_RD_DATA, OFS_FAULT_LO, OFS_FAULT_HI, OFS_INJECT: addr_hit = 1'b1;
            default: addr_hit = 1'b0;
        endcase
    end

    assign pslverr = psel & penable & ~addr_hit;

    // per-bank mode machines
    for (genvar b = 0; b < BANKS; b++) begin : g_bank
        efp_bank_fsm u_fsm (
            .pclk(pclk),
            .presetn(presetn),
            .go_prog(prog_accept && seq_bank_sel(b)),
            .go_erase(erase_accept && erase_bank_r == 2'(b)),
            .seq_done(seq_done && seq_bank_r == 2'(b)),
            .pd_req(power_down_request_r),
            .mode(bank_mode[b])
        );
        assign mode_bits[2*b +: 2] = bank_mode[b];
    end

    function automatic logic seq_bank_sel(input int b);
        seq_bank_sel = (ptr_dec[1:0] == 2'(b));
    endfunction

    // program and erase request checks
    assign prog_go = wr_acc && paddr == OFS_CTRL && pwdata[CTRL_PROG_BIT];
    assign erase_go = wr_acc && paddr == OFS_CTRL && pwdata[CTRL_ERASE_BIT];
    assign ptr_dec = addr_bank(row_address_pointer_r);
    assign ptr_ok = ptr_dec[2] && row_address_pointer_r[4:0] == 5'h00;
    assign limit_hit = ptr_dec[1:0] == D_BANK
        && !blank_r[{D_BANK, row_address_pointer_r[11:5]}]
        && dcnt_r[row_address_pointer_r[11:5]] >= D_PROG_LIMIT;
    assign prog_accept = prog_go && ptr_ok && !seq_active_r && !limit_hit
        && bank_mode[ptr_dec[1:0]] == mode_ready;
    assign erase_accept = erase_go && !prog_go && !seq_active_r && erase_mask_r != 10'h000
        && bank_mode[erase_bank_r] == mode_ready;

    // pacing timer runs the sequence in underflow steps
    assign underflow = seq_active_r && pace_cnt_r == 16'h0000;
    assign seq_done = underflow && step_cnt_r == PACE_LAST;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seq_active_r <= 1'b0;
            seq_erase_r <= 1'b0;
            seq_bank_r <= 2'h0;
            seq_wl_r <= 7'h00;
            seq_mask_r <= 10'h000;
            pace_cnt_r <= 16'h0000;
            step_cnt_r <= 8'h00;
        end else if (prog_accept) begin
            seq_active_r <= 1'b1;
            seq_erase_r <= 1'b0;
            seq_bank_r <= ptr_dec[1:0];
            seq_wl_r <= row_address_pointer_r[11:5];
            pace_cnt_r <= PACE_RELOAD;
            step_cnt_r <= 8'h00;
        end else if (erase_accept) begin
            seq_active_r <= 1'b1;
            seq_erase_r <= 1'b1;
            seq_bank_r <= erase_bank_r;
            seq_mask_r <= erase_mask_r;
            pace_cnt_r <= PACE_RELOAD;
            step_cnt_r <= 8'h00;
        end else if (seq_done) begin
            seq_active_r <= 1'b0;
        end else if (underflow) begin
            pace_cnt_r <= PACE_RELOAD;
            step_cnt_r <= step_cnt_r + 8'h01;
        end else if (seq_active_r) begin
            pace_cnt_r <= pace_cnt_r - 16'h0001;
        end
    end

    assign pump_enable = seq_active_r;

    // new wordline: old contents and buffer merged, then re-encoded
    assign seq_idx = {seq_bank_r, seq_wl_r};
    assign seq_blank = blank_r[seq_idx];
    assign seq_word = cells_r[seq_idx];

    for (genvar g = 0; g < WL_BYTES; g++) begin : g_byte
        logic [7:0] old_dec;
        logic [7:0] old_byte;
        logic [CW_W-1:0] enc_cw;
        assign old_byte = seq_blank ? ERASED_BYTE : old_dec;
        efp_ecc u_ecc (
            .enc_data(wbuf_r[seq_bank_r][g] & old_byte),
            .enc_code(enc_cw),
            .dec_code(seq_word[g*CW_W +: CW_W]),
            .dec_data(old_dec),
            .dec_single(),
            .dec_double()
        );
        assign new_word[g*CW_W +: CW_W] = enc_cw ^ inject_r;
    end

    // cell array, whole wordline written at sequence end
    always_ff @(posedge pclk) begin
        if (seq_done && !seq_erase_r) cells_r[seq_idx] <= new_word;
    end

    // erased marks; erase walks whole sectors only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            blank_r <= '1;
        end else if (seq_done && !seq_erase_r) begin
            blank_r[seq_idx] <= 1'b0;
        end else if (seq_done && seq_erase_r) begin
            for (int w = 0; w < WLS; w++) begin
                if (seq_mask_r[wl_sector(seq_bank_r == D_BANK, 7'(w))]) begin
                    blank_r[{seq_bank_r, 7'(w)}] <= 1'b1;
                end
            end
        end
    end

    // program count per data wordline
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int w = 0; w < WLS; w++) dcnt_r[w] <= 2'h0;
        end else if (seq_done && seq_bank_r == D_BANK && !seq_erase_r) begin
            dcnt_r[seq_wl_r] <= blank_r[seq_idx] ? 2'h1 : dcnt_r[seq_wl_r] + 2'h1;
        end else if (seq_done && seq_bank_r == D_BANK) begin
            for (int w = 0; w < WLS; w++) begin
                if (seq_mask_r[wl_sector(1'b1, 7'(w))]) dcnt_r[w] <= 2'h0;
            end
        end
    end

    // write buffers, filled only while the bank is ready
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int b = 0; b < BANKS; b++) begin
                for (int i = 0; i < WL_BYTES; i++) wbuf_r[b][i] <= ERASED_BYTE;
            end
        end else if (wr_acc && paddr == OFS_WBUF && bank_mode[pwdata[17:16]] == mode_ready) begin
            wbuf_r[pwdata[17:16]][pwdata[12:8]] <= pwdata[7:0];
        end
    end

    // control registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            power_down_request_r <= 1'b0;
            erase_mask_r <= 10'h000;
            erase_bank_r <= D_BANK;
            rd_addr_r <= P0_BASE;
            inject_r <= '0;
        end else if (wr_acc) begin
            case (paddr)
                OFS_CTRL: power_down_request_r <= pwdata[CTRL_PD_BIT];
                OFS_ERASE: begin
                    erase_mask_r <= pwdata[9:0];
                    erase_bank_r <= pwdata[17:16];
                end
                OFS_RD_ADDR: rd_addr_r <= pwdata[15:0];
                OFS_INJECT: inject_r <= pwdata[CW_W-1:0];
                default: ;
            endcase
        end
    end

    // row pointer, steps to the next wordline on program acceptance
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) row_address_pointer_r <= ROW_PTR_RST;
        else if (prog_accept) row_address_pointer_r <= row_address_pointer_r + ROW_STEP;
        else if (wr_acc && paddr == OFS_ROW_PTR) row_address_pointer_r <= pwdata[15:0];
    end

    // carry: set on refused request, cleared on acceptance or by software
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) request_error_carry_r <= 1'b0;
        else if ((prog_go && !prog_accept) || (erase_go && !erase_accept))
            request_error_carry_r <= 1'b1;
        else if (prog_accept || erase_accept) request_error_carry_r <= 1'b0;
        else if (wr_acc && paddr == OFS_STATUS && pwdata[ST_CARRY_BIT])
            request_error_carry_r <= 1'b0;
    end

    // pacing nmi enable: on for a data-bank sequence, off at its end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) pacing_timer_nmi_enable_r <= 1'b0;
        else if ((prog_accept && ptr_dec[1:0] == D_BANK) || (erase_accept && erase_bank_r == D_BANK))
            pacing_timer_nmi_enable_r <= 1'b1;
        else if (seq_done) pacing_timer_nmi_enable_r <= 1'b0;
    end

    // pacing flag, set on each data-bank underflow; set beats clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) pacing_timer_nmi_flag_r <= 1'b0;
        else if (underflow && seq_bank_r == D_BANK) pacing_timer_nmi_flag_r <= 1'b1;
        else if (wr_acc && paddr == OFS_STATUS && pwdata[ST_PFLAG_BIT])
            pacing_timer_nmi_flag_r <= 1'b0;
    end

    assign pacing_nmi = pacing_timer_nmi_flag_r & pacing_timer_nmi_enable_r;

    // cpu read path through the decoder
    assign rd_dec = addr_bank(rd_addr_r);
    assign rd_idx = {rd_dec[1:0], rd_addr_r[11:5]};
    assign rd_word = blank_r[rd_idx] ? {WL_BYTES{ERASED_CW}} : cells_r[rd_idx];
    assign rd_code = rd_word[rd_addr_r[4:0]*CW_W +: CW_W];
    assign rd_blocked = !rd_dec[2] || bank_mode[rd_dec[1:0]] != mode_ready;

    efp_ecc u_rd_ecc (
        .enc_data(8'h00),
        .enc_code(),
        .dec_code(rd_code),
        .dec_data(rd_byte),
        .dec_single(rd_single),
        .dec_double(rd_double)
    );

    assign ecc_event = rd_acc && paddr == OFS_RD_DATA && !rd_blocked
        && (rd_single || rd_double);

    // ecc flag shared by both error kinds; set beats clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) ecc_flag_r <= 1'b0;
        else if (ecc_event) ecc_flag_r <= 1'b1;
        else if (wr_acc && paddr == OFS_STATUS && pwdata[ST_ECC_BIT]) ecc_flag_r <= 1'b0;
    end

    assign ecc_nmi = ecc_flag_r;

    // fault address, replaced by every new error
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ecc_fault_addr_low_r <= 8'h00;
            ecc_fault_addr_high_r <= 8'h00;
        end else if (ecc_event) begin
            ecc_fault_addr_low_r <= rd_addr_r[7:0];
            ecc_fault_addr_high_r <= rd_addr_r[15:8];
        end
    end

    // read data captured in the setup phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_setup) begin
            case (paddr)
                OFS_CTRL: prdata <= {31'h0000_0000, power_down_request_r};
                OFS_ROW_PTR: prdata <= {16'h0000, row_address_pointer_r};
                OFS_ERASE: prdata <= {14'h0000, erase_bank_r, 6'h00, erase_mask_r};
                OFS_STATUS: prdata <= {16'h0000, mode_bits, 3'h0, seq_active_r, ecc_flag_r,
                    pacing_timer_nmi_flag_r, pacing_timer_nmi_enable_r, request_error_carry_r};
                OFS_RD_ADDR: prdata <= {16'h0000, rd_addr_r};
                OFS_RD_DATA: prdata <= {22'h00_0000, rd_blocked, rd_blocked ? 1'b0 : rd_double,
                    rd_blocked ? 8'h00 : rd_byte};
                OFS_FAULT_LO: prdata <= {24'h00_0000, ecc_fault_addr_low_r};
                OFS_FAULT_HI: prdata <= {24'h00_0000, ecc_fault_addr_high_r};
                OFS_INJECT: prdata <= {19'h0_0000, inject_r};
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end
endmodule // efp_flash_ctrl
`default_nettype wire

// ==== efp_flash_ctrl_sva.sv ====
// port-level assertions for the flash controller
`timescale 1ns/10ps
`default_nettype none
module efp_flash_ctrl_sva
    import efp_pkg::*;
#(
    parameter int PACE_CYCLES = PACE_CYCLES_DEF,
    parameter int PACE_STEPS = PACE_STEPS_DEF
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic pump_enable,
    input wire logic ecc_nmi,
    input wire logic pacing_nmi
);
    int cnt_r;
    logic acc;
    assign acc = psel && penable;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // cycles the pumps have been on
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) cnt_r <= 0;
        else cnt_r <= pump_enable ? cnt_r + 1 : 0;
    end
    AST_READY: assert property (acc |-> pready) else $error("no ready");
    AST_SLVERR: assert property (acc && paddr[1:0] == 2'h0 |-> pslverr == (paddr > OFS_INJECT))
        else $error("bad slverr");
    AST_PUMP_CAUSE: assert property ($rose(pump_enable) |->
        $past(acc && pwrite && paddr == OFS_CTRL && pwdata[2:1] != 2'h0)) else $error("pump cause");
    AST_PUMP_LEN: assert property ($fell(pump_enable) |-> cnt_r == PACE_CYCLES * PACE_STEPS)
        else $error("pump length");
    AST_ONE_SEQ: assert property (cnt_r <= PACE_CYCLES * PACE_STEPS) else $error("overlap");
    AST_PACE_RUN: assert property (pacing_nmi |-> pump_enable) else $error("pacing idle");
    AST_PACE_END: assert property ($fell(pump_enable) |-> !pacing_nmi) else $error("pace end");
    AST_ECC_CAUSE: assert property ($rose(ecc_nmi) |->
        $past(acc && !pwrite && paddr == OFS_RD_DATA)) else $error("ecc cause");
    AST_ECC_HOLD: assert property (ecc_nmi && !(acc && pwrite && paddr == OFS_STATUS && pwdata[3])
        |=> ecc_nmi) else $error("ecc lost");
    COV_SEQ: cover property ($fell(pump_enable));
    COV_ECC: cover property ($rose(ecc_nmi));
    COV_PACE: cover property ($rose(pacing_nmi));
endmodule // efp_flash_ctrl_sva
`default_nettype wire

// ==== efp_cpu_model.sv ====
// cpu side apb master model for the flash controller
`timescale 1ns/10ps
`default_nettype none
module efp_cpu_model (
    input wire logic pclk,
    input wire logic pready,
    input wire logic [31:0] prdata,
    output logic [7:0] paddr,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [31:0] pwdata,
    output logic [3:0] pstrb
);
    initial {paddr, psel, penable, pwrite, pwdata, pstrb} = '0;
    // setup, access held until pready for up to 20 cycles, then release with scrambled lines
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q, output logic ok);
        ok = 1'b0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= 4'hF;
        @(posedge pclk);
        penable <= 1'b1;
        for (int i = 0; i < 20 && !ok; i++) begin
            @(posedge pclk);
            ok = (pready === 1'b1);
        end
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~d;
    endtask
endmodule // efp_cpu_model
`default_nettype wire

// ==== embedded_flash_program_erase_ecc_tb_top.sv ====
// self-checking testbench for the flash controller
`timescale 1ns/10ps
`default_nettype none
module embedded_flash_program_erase_ecc_tb_top
    import efp_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, pump_enable, ecc_nmi, pacing_nmi;
    logic [7:0] paddr;
    logic [3:0] pstrb;
    logic [31:0] pwdata, prdata, q, e, m;
    logic [7:0] img [32];
    logic [31:0] exp_q [$];
    logic [31:0] msk_q [$];
    int n_errors = 0;
    int samples_checked = 0;
    always #25 pclk = ~pclk;
    efp_flash_ctrl #(.PACE_CYCLES(4), .PACE_STEPS(4)) u_dut (.pclk, .presetn, .paddr, .psel,
        .penable, .pwrite, .pwdata, .pstrb, .prdata, .pready, .pslverr, .pump_enable, .ecc_nmi,
        .pacing_nmi);
    efp_cpu_model u_cpu (.pclk, .pready, .prdata, .paddr, .psel, .penable, .pwrite, .pwdata,
        .pstrb);
    task automatic end_of_test();
        if (n_errors == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // one bus cycle; a read notes its expected value and mask
    task automatic bus(input int w, input logic [7:0] a, input logic [31:0] d,
        input logic [31:0] k);
        logic ok;
        if (w == 0) begin
            exp_q.push_back(d);
            msk_q.push_back(k);
        end
        u_cpu.xfer(w != 0, a, d, q, ok);
        if (!ok) begin
            n_errors++;
            $display("CHECK FAILED %0t no pready", $time);
            end_of_test();
        end
    endtask
    task automatic fl(input logic [15:0] a, input logic [31:0] d, input logic [31:0] k);
        bus(1, OFS_RD_ADDR, {16'h0, a}, 0);
        bus(0, OFS_RD_DATA, d, k);
    endtask
    task automatic prog(input logic [15:0] a);
        bus(1, OFS_ROW_PTR, {16'h0, a}, 0);
        bus(1, OFS_CTRL, 32'h2, 0);
    endtask
    task automatic idle();
        for (int i = 0; i < 30; i++) begin
            bus(0, OFS_STATUS, 0, 0);
            if (q[4] === 1'b0) return;
        end
        n_errors++;
        $display("CHECK FAILED %0t still busy", $time);
        end_of_test();
    endtask
    // pump, pacing nmi and ecc nmi pins, looked at on the falling edge
    task automatic pins(input logic [2:0] x);
        @(negedge pclk);
        samples_checked++;
        if ({pump_enable, pacing_nmi, ecc_nmi} !== x) begin
            n_errors++;
            $display("CHECK FAILED %0t pins exp %b", $time, x);
        end
    endtask
    task automatic row();
        for (int i = 0; i < 32; i++) fl(16'hA000 + 16'(i), {24'h0, img[i]}, 32'h3FF);
    endtask
    always @(posedge pclk) begin
        if ((psel & penable & pready & ~pwrite) === 1'b1 && exp_q.size() > 0) begin
            e = exp_q.pop_front();
            m = msk_q.pop_front();
            if (m != 0) samples_checked++;
            if ((prdata & m) !== (e & m)) begin
                n_errors++;
                $display("CHECK FAILED %0t addr %h got %h exp %h", $time, paddr, prdata, e);
            end
        end
    end
    initial begin
        void'($urandom(98033));
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        bus(0, OFS_STATUS, 0, 32'hFFFF);
        bus(0, 8'h28, 0, 32'hFFFFFFFF);
        bus(1, OFS_RD_ADDR, 0, 0);
        for (int i = 0; i < 32; i++) begin
            img[i] = 8'($urandom);
            bus(1, OFS_WBUF, {14'h0, 2'h3, 3'h0, 5'(i), img[i]}, 0);
        end
        prog(16'hA000);
        bus(0, OFS_RD_DATA, 32'hFF, 32'h3FF);
        bus(1, OFS_RD_ADDR, 32'hA000, 0);
        bus(0, OFS_RD_DATA, 32'h200, 32'h3FF);
        bus(0, OFS_STATUS, 32'h4012, 32'hFFFB);
        pins(3'b110);
        idle();
        bus(0, OFS_STATUS, 32'h4, 32'hFFFF);
        pins(3'b000);
        bus(0, OFS_ROW_PTR, 32'hA020, 32'hFFFF);
        row();
        img[0] = img[0] & 8'h0F;
        bus(1, OFS_WBUF, 32'h3000F, 0);
        prog(16'hA000);
        idle();
        row();
        prog(16'hA000);
        bus(0, OFS_STATUS, 32'h1, 32'h11);
        for (int j = 0; j < 2; j++) begin
            bus(1, OFS_STATUS, 32'h1, 0);
            prog(j ? 16'hA010 : 16'h5000);
            bus(0, OFS_STATUS, 32'h1, 32'h11);
        end
        bus(1, OFS_ERASE, 32'h30001, 0);
        bus(1, OFS_CTRL, 32'h4, 0);
        bus(0, OFS_STATUS, 32'h8010, 32'hC010);
        idle();
        for (int i = 0; i < 32; i++) img[i] = 8'hFF;
        row();
        bus(1, OFS_INJECT, 32'h1, 0);
        bus(1, OFS_WBUF, 32'h1055A, 0);
        prog(16'h1000);
        idle();
        bus(1, OFS_INJECT, 0, 0);
        fl(16'h1005, 32'h5A, 32'h3FF);
        bus(0, OFS_FAULT_LO, 32'h05, 32'hFF);
        bus(0, OFS_FAULT_HI, 32'h10, 32'hFF);
        bus(0, OFS_STATUS, 32'h8, 32'h8);
        pins(3'b001);
        bus(1, OFS_INJECT, 32'h3, 0);
        prog(16'h1020);
        idle();
        bus(1, OFS_INJECT, 0, 0);
        fl(16'h1025, 32'h100, 32'h100);
        bus(0, OFS_FAULT_LO, 32'h25, 32'hFF);
        bus(1, OFS_CTRL, 32'h1, 0);
        bus(0, OFS_STATUS, 32'hFF00, 32'hFF00);
        fl(16'hA000, 32'h200, 32'h3FF);
        bus(1, OFS_CTRL, 0, 0);
        bus(0, OFS_STATUS, 0, 32'hFF00);
        fl(16'hA000, 32'hFF, 32'h3FF);
        end_of_test();
    end
endmodule // embedded_flash_program_erase_ecc_tb_top
bind efp_flash_ctrl efp_flash_ctrl_sva #(.PACE_CYCLES(PACE_CYCLES), .PACE_STEPS(PACE_STEPS))
    u_sva (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pready, .pslverr,
    .pump_enable, .ecc_nmi, .pacing_nmi);
`default_nettype wire
